//--- logic/config_word_pkg.sv
// constants, field positions and carrier types for the configuration word decoder
`default_nettype none
package config_word_pkg;

  // configuration word locations in program space
  localparam logic [15:0] CFG_BASE_ADDR       = 16'h8007;
  localparam logic [15:0] OSC_WORD_ADDR       = 16'h8007;
  localparam logic [15:0] SUP_WORD_ADDR       = 16'h8008;

  // register port offsets
  localparam logic [3:0]  OFS_OSC_WORD        = 4'h0;
  localparam logic [3:0]  OFS_SUP_WORD        = 4'h1;
  localparam logic [3:0]  OFS_PROG_WORD       = 4'h2;
  localparam logic [3:0]  OFS_STATUS          = 4'h3;
  localparam logic [3:0]  OFS_SOFT_CTRL       = 4'h4;

  localparam int          WORD_W              = 14;

  // unimplemented positions, forced to one on read back
  localparam logic [13:0] OSC_UNIMPL_MASK     = 14'h1688;
  localparam logic [13:0] SUP_UNIMPL_MASK     = 14'h011C;
  localparam logic [13:0] WORD_RESET          = 14'h3FFF;

  // oscillator word fields
  localparam int          OSC_FAILSAFE_BIT    = 13;
  localparam int          OSC_SWITCH_BIT      = 11;
  localparam int          OSC_CLKOUT_N_BIT    = 8;
  localparam int          OSC_RST_LSB         = 4;
  localparam int          OSC_EXT_LSB         = 0;

  // supervisor word fields
  localparam int          SUP_DEBUG_N_BIT     = 13;
  localparam int          SUP_STACK_RST_BIT   = 12;
  localparam int          SUP_PIN_ONESHOT_BIT = 11;
  localparam int          SUP_ZCD_DIS_BIT     = 10;
  localparam int          SUP_BOR_LEVEL_BIT   = 9;
  localparam int          SUP_BOR_MODE_LSB    = 6;
  localparam int          SUP_LPBOR_N_BIT     = 5;
  localparam int          SUP_PWRT_N_BIT      = 1;
  localparam int          SUP_MASTER_CLEAR_PIN_EN_BIT     = 0;

  // programming word fields (low-voltage programming, code protection)
  localparam int          PROG_LVP_BIT        = 1;
  localparam int          PROG_CP_N_BIT       = 0;

  // soft control and status register bits
  localparam int          SOFT_ZCD_BIT        = 0;
  localparam int          SOFT_BOR_BIT        = 1;
  localparam int          STAT_OVF_BIT        = 0;
  localparam int          STAT_UNF_BIT        = 1;

  // fast internal oscillator frequency codes and divider code
  localparam logic [2:0]  FAST_FRQ_DEFAULT    = 3'h6;
  localparam logic [2:0]  FAST_FRQ_ALT        = 3'h2;
  localparam logic [3:0]  DIV_ONE             = 4'h0;

  typedef enum logic [2:0] {
    RST_OSC_EXT       = 3'b111,
    RST_OSC_FAST_ALT  = 3'b110,
    RST_OSC_SLOW      = 3'b101,
    RST_OSC_SECONDARY = 3'b100,
    RST_OSC_RESERVED  = 3'b011,
    RST_OSC_EXT_X4    = 3'b010,
    RST_OSC_EXT_X2    = 3'b001,
    RST_OSC_FAST      = 3'b000
  } reset_osc_type;

  typedef enum logic [2:0] {
    EXT_CLOCK_HIGH    = 3'b111,
    EXT_CLOCK_MID     = 3'b110,
    EXT_CLOCK_LOW     = 3'b101,
    EXT_OFF           = 3'b100,
    EXT_RESERVED      = 3'b011,
    EXT_CRYSTAL_HIGH  = 3'b010,
    EXT_CRYSTAL_MID   = 3'b001,
    EXT_CRYSTAL_LOW   = 3'b000
  } ext_mode_type;

  typedef enum logic [1:0] {
    BOR_ALWAYS = 2'b11,
    BOR_AWAKE  = 2'b10,
    BOR_SOFT   = 2'b01,
    BOR_OFF    = 2'b00
  } bor_mode_type;

  // program memory power level
  typedef enum logic [1:0] {
    PMEM_LOW  = 2'b00,
    PMEM_MID  = 2'b01,
    PMEM_HIGH = 2'b10
  } pmem_power_type;

  // oscillator selection handed to the clock logic
  typedef struct packed {
    logic           failsafe_monitor_enable;
    logic           clock_switch_permit;
    logic           clkout_active;
    reset_osc_type  current_oscillator_select;
    logic           use_external;
    logic [1:0]     pll_factor;
    logic [2:0]     fast_osc_frequency_select;
    logic [3:0]     clock_divider_select;
    logic           external_clock_mode;
    logic           crystal_mode;
    logic           osc_enabled;
    pmem_power_type program_memory_power;
  } osc_cfg_type;

  // supervisor settings handed to reset and pin logic
  typedef struct packed {
    logic debugger_enable;
    logic stack_fault_reset_enable;
    logic pin_select_one_shot_lock;
    logic zero_cross_active;
    logic brownout_low_level;
    logic brownout_active;
    logic brownout_in_sleep;
    logic ultra_low_power_brownout;
    logic powerup_timer_enable;
    logic master_clear_active;
    logic low_voltage_prog_enable;
    logic code_protect_active;
  } sup_cfg_type;

endpackage
`default_nettype wire

//--- logic/config_word_decoder.sv
// configuration word latch and decoder for clock, reset and pin setup
`default_nettype none

module config_word_decoder (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // nonvolatile words as presented by the memory
  input  wire logic [13:0]                 nvm_osc_word_i,
  input  wire logic [13:0]                 nvm_sup_word_i,
  input  wire logic [1:0]                  nvm_prog_bits_i,
  // stack fault events from the core
  input  wire logic                        stack_overflow_i,
  input  wire logic                        stack_underflow_i,
  // pin-select lock requests from software
  input  wire logic                        pin_lock_set_i,
  input  wire logic                        pin_lock_clear_i,
  // sleep state
  input  wire logic                        sleep_i,
  // register port
  input  wire logic [3:0]                  reg_addr_i,
  input  wire logic [13:0]                 reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [13:0]                 reg_rdata_o,
  // decoded settings
  output config_word_pkg::osc_cfg_type     osc_cfg_o,
  output config_word_pkg::sup_cfg_type     sup_cfg_o,
  output logic                             clkout_o,
  output logic                             stack_reset_o,
  output logic                             pin_select_lock_o,
  output logic                             zero_cross_enable_o,
  output logic                             brownout_enable_o
);

  logic [13:0] osc_word_q, osc_word_d;
  logic [13:0] sup_word_q, sup_word_d;
  logic [1:0]  prog_q,     prog_d;
  config_word_pkg::osc_cfg_type osc_cfg_q, osc_cfg_d;
  config_word_pkg::sup_cfg_type sup_cfg_q, sup_cfg_d;
  logic        clk_div_q,  clk_div_d;
  logic        clkout_q,   clkout_d;
  logic        ovf_q,      ovf_d;
  logic        unf_q,      unf_d;
  logic        stk_rst_q,  stk_rst_d;
  logic        lock_q,     lock_d;
  logic        lock_used_q, lock_used_d;
  logic        soft_zcd_q, soft_zcd_d;
  logic        soft_bor_q, soft_bor_d;
  logic [13:0] rdata_q,    rdata_d;

  // words seen with the unimplemented positions forced high
  function automatic logic [13:0] fill_unimpl(input logic [13:0] w, input logic [13:0] m);
    fill_unimpl = w | m;
  endfunction

  function automatic config_word_pkg::osc_cfg_type decode_osc(input logic [13:0] w);
    config_word_pkg::osc_cfg_type c;
    config_word_pkg::ext_mode_type em;
    c  = '0;
    em = config_word_pkg::ext_mode_type'(w[config_word_pkg::OSC_EXT_LSB +: 3]);
    c.failsafe_monitor_enable = w[config_word_pkg::OSC_FAILSAFE_BIT];
    c.clock_switch_permit     = w[config_word_pkg::OSC_SWITCH_BIT];
    c.current_oscillator_select =
      config_word_pkg::reset_osc_type'(w[config_word_pkg::OSC_RST_LSB +: 3]);
    c.fast_osc_frequency_select = config_word_pkg::FAST_FRQ_DEFAULT;
    c.clock_divider_select      = config_word_pkg::DIV_ONE;
    unique case (c.current_oscillator_select)
      config_word_pkg::RST_OSC_EXT: begin
        c.use_external = 1'b1;
      end
      config_word_pkg::RST_OSC_EXT_X4: begin
        c.use_external = 1'b1;
        c.pll_factor   = 2'h2;
      end
      config_word_pkg::RST_OSC_EXT_X2: begin
        c.use_external = 1'b1;
        c.pll_factor   = 2'h1;
      end
      config_word_pkg::RST_OSC_FAST: begin
        c.fast_osc_frequency_select = config_word_pkg::FAST_FRQ_DEFAULT;
        c.clock_divider_select      = config_word_pkg::DIV_ONE;
      end
      config_word_pkg::RST_OSC_FAST_ALT: begin
        c.fast_osc_frequency_select = config_word_pkg::FAST_FRQ_ALT;
      end
      config_word_pkg::RST_OSC_SLOW,
      config_word_pkg::RST_OSC_SECONDARY,
      config_word_pkg::RST_OSC_RESERVED: begin
        c.use_external = 1'b0; // reserved code treated as no external source
      end
    endcase
    unique case (em)
      config_word_pkg::EXT_CLOCK_HIGH: begin
        c.external_clock_mode  = 1'b1;
        c.osc_enabled          = 1'b1;
        c.program_memory_power = config_word_pkg::PMEM_HIGH;
      end
      config_word_pkg::EXT_CLOCK_MID: begin
        c.external_clock_mode  = 1'b1;
        c.osc_enabled          = 1'b1;
        c.program_memory_power = config_word_pkg::PMEM_MID;
      end
      config_word_pkg::EXT_CLOCK_LOW: begin
        c.external_clock_mode  = 1'b1;
        c.osc_enabled          = 1'b1;
        c.program_memory_power = config_word_pkg::PMEM_LOW;
      end
      config_word_pkg::EXT_OFF,
      config_word_pkg::EXT_RESERVED: begin
        c.osc_enabled = 1'b0;
      end
      config_word_pkg::EXT_CRYSTAL_HIGH: begin
        c.crystal_mode         = 1'b1;
        c.osc_enabled          = 1'b1;
        c.program_memory_power = config_word_pkg::PMEM_HIGH;
      end
      config_word_pkg::EXT_CRYSTAL_MID: begin
        c.crystal_mode         = 1'b1;
        c.osc_enabled          = 1'b1;
        c.program_memory_power = config_word_pkg::PMEM_MID;
      end
      config_word_pkg::EXT_CRYSTAL_LOW: begin
        c.crystal_mode         = 1'b1;
        c.osc_enabled          = 1'b1;
        c.program_memory_power = config_word_pkg::PMEM_LOW;
      end
    endcase
    // clock-out only where the second pin is free of a crystal
    c.clkout_active = !w[config_word_pkg::OSC_CLKOUT_N_BIT] &&
                      (c.external_clock_mode || em == config_word_pkg::EXT_OFF);
    decode_osc = c;
  endfunction

  function automatic config_word_pkg::sup_cfg_type decode_sup(input logic [13:0] w,
                                                            input logic [1:0]  p);
    config_word_pkg::sup_cfg_type s;
    config_word_pkg::bor_mode_type bm;
    s  = '0;
    bm = config_word_pkg::bor_mode_type'(w[config_word_pkg::SUP_BOR_MODE_LSB +: 2]);
    s.debugger_enable          = !w[config_word_pkg::SUP_DEBUG_N_BIT];
    s.stack_fault_reset_enable = w[config_word_pkg::SUP_STACK_RST_BIT];
    s.pin_select_one_shot_lock = w[config_word_pkg::SUP_PIN_ONESHOT_BIT];
    s.zero_cross_active        = !w[config_word_pkg::SUP_ZCD_DIS_BIT];
    s.brownout_low_level       = w[config_word_pkg::SUP_BOR_LEVEL_BIT];
    s.brownout_active   = (bm == config_word_pkg::BOR_ALWAYS) ||
                          (bm == config_word_pkg::BOR_AWAKE);
    s.brownout_in_sleep = (bm == config_word_pkg::BOR_ALWAYS);
    s.ultra_low_power_brownout = !w[config_word_pkg::SUP_LPBOR_N_BIT];
    s.powerup_timer_enable     = !w[config_word_pkg::SUP_PWRT_N_BIT];
    s.low_voltage_prog_enable  = p[config_word_pkg::PROG_LVP_BIT];
    s.master_clear_active      = p[config_word_pkg::PROG_LVP_BIT] ||
                                 w[config_word_pkg::SUP_MASTER_CLEAR_PIN_EN_BIT];
    s.code_protect_active      = !p[config_word_pkg::PROG_CP_N_BIT];
    decode_sup = s;
  endfunction

  logic [1:0] bor_mode;
  assign bor_mode = sup_word_q[config_word_pkg::SUP_BOR_MODE_LSB +: 2];

  always_comb begin
    // capture only while reset is held, so settings are frozen in operation
    osc_word_d  = osc_word_q;
    sup_word_d  = sup_word_q;
    prog_d      = prog_q;
    osc_cfg_d   = osc_cfg_q;
    sup_cfg_d   = sup_cfg_q;
    if (rst_i) begin
      osc_word_d = fill_unimpl(nvm_osc_word_i, config_word_pkg::OSC_UNIMPL_MASK);
      sup_word_d = fill_unimpl(nvm_sup_word_i, config_word_pkg::SUP_UNIMPL_MASK);
      prog_d     = nvm_prog_bits_i;
      osc_cfg_d  = decode_osc(fill_unimpl(nvm_osc_word_i, config_word_pkg::OSC_UNIMPL_MASK));
      sup_cfg_d  = decode_sup(nvm_sup_word_i, nvm_prog_bits_i);
    end
  end

  always_comb begin
    clk_div_d = !clk_div_q;
    clkout_d  = clkout_q;
    if (osc_cfg_q.clkout_active && clk_div_q) begin
      clkout_d = !clkout_q; // toggle every two clocks gives clock/4
    end
    if (!osc_cfg_q.clkout_active) begin
      clkout_d = 1'b0;
    end
  end

  always_comb begin
    ovf_d       = ovf_q;
    unf_d       = unf_q;
    stk_rst_d   = 1'b0;
    lock_d      = lock_q;
    lock_used_d = lock_used_q;
    soft_zcd_d  = soft_zcd_q;
    soft_bor_d  = soft_bor_q;
    rdata_d     = rdata_q;
    // software clear of flags first, so a same-cycle event wins
    if (reg_wr_i && reg_addr_i == config_word_pkg::OFS_STATUS) begin
      ovf_d = ovf_q & !reg_wdata_i[config_word_pkg::STAT_OVF_BIT];
      unf_d = unf_q & !reg_wdata_i[config_word_pkg::STAT_UNF_BIT];
    end
    if (reg_wr_i && reg_addr_i == config_word_pkg::OFS_SOFT_CTRL) begin
      soft_zcd_d = reg_wdata_i[config_word_pkg::SOFT_ZCD_BIT];
      soft_bor_d = reg_wdata_i[config_word_pkg::SOFT_BOR_BIT];
    end
    if (stack_overflow_i) begin
      ovf_d = 1'b1;
    end
    if (stack_underflow_i) begin
      unf_d = 1'b1;
    end
    stk_rst_d = sup_cfg_q.stack_fault_reset_enable &&
                (stack_overflow_i || stack_underflow_i);
    // once the one-shot cycle is used, the lock can no longer be released
    if (pin_lock_clear_i && !(sup_cfg_q.pin_select_one_shot_lock && lock_used_q)) begin
      lock_d = 1'b0;
    end
    if (pin_lock_set_i) begin
      lock_d = 1'b1;
      if (!lock_q) begin
        lock_used_d = 1'b1;
      end
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        config_word_pkg::OFS_OSC_WORD:  rdata_d = osc_word_q;
        config_word_pkg::OFS_SUP_WORD:  rdata_d = sup_word_q;
        config_word_pkg::OFS_PROG_WORD: rdata_d = {12'h000, prog_q};
        config_word_pkg::OFS_STATUS:    rdata_d = {12'h000, unf_q, ovf_q};
        config_word_pkg::OFS_SOFT_CTRL: rdata_d = {12'h000, soft_bor_q, soft_zcd_q};
        default:                        rdata_d = 14'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    osc_word_q <= osc_word_d;
    sup_word_q <= sup_word_d;
    prog_q     <= prog_d;
    osc_cfg_q  <= osc_cfg_d;
    sup_cfg_q  <= sup_cfg_d;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      clk_div_q   <= 1'b0;
      clkout_q    <= 1'b0;
      stk_rst_q   <= 1'b0;
      lock_q      <= 1'b0;
      lock_used_q <= 1'b0;
      soft_zcd_q  <= 1'b0;
      soft_bor_q  <= 1'b0;
      rdata_q     <= 14'h0000;
    end else begin
      clk_div_q   <= clk_div_d;
      clkout_q    <= clkout_d;
      stk_rst_q   <= stk_rst_d;
      lock_q      <= lock_d;
      lock_used_q <= lock_used_d;
      soft_zcd_q  <= soft_zcd_d;
      soft_bor_q  <= soft_bor_d;
      rdata_q     <= rdata_d;
    end
  end

  // stack flags must survive the reset they cause
  always_ff @(posedge sys_clk_i) begin
    ovf_q <= ovf_d;
    unf_q <= unf_d;
  end

  assign reg_rdata_o         = rdata_q;
  assign osc_cfg_o           = osc_cfg_q;
  assign sup_cfg_o           = sup_cfg_q;
  assign clkout_o            = clkout_q;
  assign stack_reset_o       = stk_rst_q;
  assign pin_select_lock_o   = lock_q;
  assign zero_cross_enable_o = sup_cfg_q.zero_cross_active || soft_zcd_q;
  assign brownout_enable_o   = (bor_mode == config_word_pkg::BOR_ALWAYS) ||
                               (bor_mode == config_word_pkg::BOR_AWAKE && !sleep_i) ||
                               (bor_mode == config_word_pkg::BOR_SOFT && soft_bor_q);

endmodule
`default_nettype wire

//--- dv/config_word_decoder_chk.sv
// assertion checker for the configuration word decoder ports
`default_nettype none
module config_word_decoder_chk (
  // clock, reset and requests
  input wire logic                         sys_clk_i,
  input wire logic                         rst_i,
  input wire logic [3:0]                   reg_addr_i,
  input wire logic                         reg_rd_i,
  input wire logic                         stack_overflow_i,
  input wire logic                         stack_underflow_i,
  input wire logic                         pin_lock_set_i,
  input wire logic                         pin_lock_clear_i,
  // outputs under watch
  input wire logic [13:0]                  reg_rdata_o,
  input wire config_word_pkg::osc_cfg_type osc_cfg_o,
  input wire config_word_pkg::sup_cfg_type sup_cfg_o,
  input wire logic                         clkout_o,
  input wire logic                         stack_reset_o,
  input wire logic                         pin_select_lock_o,
  input wire logic                         zero_cross_enable_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_unimpl_ones: assert property (
    $past(reg_rd_i) && !$past(rst_i) && $past(reg_addr_i) < 4'h2 |->
    &(reg_rdata_o | ~(($past(reg_addr_i) == 4'h1) ? config_word_pkg::SUP_UNIMPL_MASK
                                                  : config_word_pkg::OSC_UNIMPL_MASK)))
    else $error("unimplemented bit read as zero");
  a_cfg_frozen: assert property (!$past(rst_i) |-> $stable(osc_cfg_o) && $stable(sup_cfg_o))
    else $error("decoded setting changed outside reset");
  a_stack_fwd: assert property (
    (stack_overflow_i || stack_underflow_i) && sup_cfg_o.stack_fault_reset_enable |=> stack_reset_o)
    else $error("stack fault gave no reset");
  a_stack_cause: assert property (stack_reset_o && !$past(rst_i) |->
    $past(stack_overflow_i || stack_underflow_i) && sup_cfg_o.stack_fault_reset_enable)
    else $error("stack reset without enabled fault");
  a_clkout_wave: assert property (
    $rose(clkout_o) |=> clkout_o ##1 !clkout_o [*2] ##1 clkout_o)
    else $error("clock output not a divide by four");
  a_clkout_idle: assert property (!osc_cfg_o.clkout_active |-> !clkout_o)
    else $error("clock output toggles while disabled");
  a_lock_hold: assert property (
    !$past(pin_lock_set_i) && !$past(pin_lock_clear_i) && !$past(rst_i) |->
    $stable(pin_select_lock_o))
    else $error("lock moved without request");
  a_lock_set: assert property ($past(pin_lock_set_i) && !$past(rst_i) |-> pin_select_lock_o)
    else $error("lock set request ignored");
  a_zcd_forced: assert property (sup_cfg_o.zero_cross_active |-> zero_cross_enable_o)
    else $error("forced zero-cross not enabled");
  a_master_clear_pin_lvp: assert property (
    sup_cfg_o.low_voltage_prog_enable |-> sup_cfg_o.master_clear_active)
    else $error("master clear off under low-voltage programming");

  c_stack_reset: cover property (stack_reset_o);
  c_lock_refused: cover property (pin_lock_clear_i && pin_select_lock_o ##1 pin_select_lock_o);
  c_clkout_run: cover property ($rose(clkout_o));
endmodule

bind config_word_decoder config_word_decoder_chk chk_u (
  .sys_clk_i, .rst_i, .reg_addr_i, .reg_rd_i, .stack_overflow_i, .stack_underflow_i,
  .pin_lock_set_i, .pin_lock_clear_i, .reg_rdata_o, .osc_cfg_o, .sup_cfg_o, .clkout_o,
  .stack_reset_o, .pin_select_lock_o, .zero_cross_enable_o
);
`default_nettype wire

//--- dv/config_word_decoder_tb_top.sv
// self-checking bench for the configuration word decoder
`default_nettype none
module config_word_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                         sys_clk_i;
  logic                         rst_i;
  logic [13:0]                  n_o, n_s, ow, sw, wdata, rdata;
  logic [1:0]                   n_p, pb;
  logic [3:0]                   ev, addr;
  logic                         sleep, wr, rd, rd_seen;
  logic                         clkout, sreset, lock, zcd, bor, ca, prev;
  logic [2:0]                   ext, ro;
  logic [1:0]                   mode;
  config_word_pkg::osc_cfg_type oc;
  config_word_pkg::sup_cfg_type sc;
  logic [13:0]                  eq[$];
  logic [31:0]                  seed;
  int                           bad_count, tests_run, cycles, tg;

  config_word_decoder dut_u (
    .sys_clk_i           (sys_clk_i),
    .rst_i               (rst_i),
    .nvm_osc_word_i      (n_o),
    .nvm_sup_word_i      (n_s),
    .nvm_prog_bits_i     (n_p),
    .stack_overflow_i    (ev[3]),
    .stack_underflow_i   (ev[2]),
    .pin_lock_set_i      (ev[1]),
    .pin_lock_clear_i    (ev[0]),
    .sleep_i             (sleep),
    .reg_addr_i          (addr),
    .reg_wdata_i         (wdata),
    .reg_wr_i            (wr),
    .reg_rd_i            (rd),
    .reg_rdata_o         (rdata),
    .osc_cfg_o           (oc),
    .sup_cfg_o           (sc),
    .clkout_o            (clkout),
    .stack_reset_o       (sreset),
    .pin_select_lock_o   (lock),
    .zero_cross_enable_o (zcd),
    .brownout_enable_o   (bor)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [13:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
  endtask

  // the expectation is queued here; the monitor below pairs it with the answer
  task automatic reg_rd(input logic [3:0] a, input logic [13:0] e);
    eq.push_back(e);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge sys_clk_i);
    ev <= v;
    @(posedge sys_clk_i);
    ev <= 4'h0;
    #1;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // read data appears in the cycle after the strobe and holds until the next read
  always @(posedge sys_clk_i) begin
    if (rd_seen && eq.size() > 0) chk(rdata, eq.pop_front());
    rd_seen <= rd;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      end_of_test();
    end
  end

  initial begin
    {rst_i, ev, sleep, addr, wdata, wr, rd, rd_seen} = '0;
    rst_i = 1'b1;
    {n_o, n_s, n_p} = '0;
    seed = 32'h19B6;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      ow = seed[13:0];
      ow[6:4] = i[2:0];
      ow[2:0] = 3'(i * 3);
      ow[8] = i[3];
      seed = lfsr(seed);
      sw = seed[13:0];
      sw[7:6] = i[1:0];
      pb = seed[15:14];
      @(posedge sys_clk_i);
      n_o   <= ow;
      n_s   <= sw;
      n_p   <= pb;
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      seed = lfsr(seed);
      rst_i <= 1'b0;
      n_o   <= seed[13:0];
      n_s   <= seed[27:14];
      n_p   <= seed[29:28];
      sleep <= 1'b0;
      @(posedge sys_clk_i);
      #1;
      ext = ow[2:0];
      ro  = ow[6:4];
      ca  = !ow[8] && ext >= 3'h4;
      chk({oc.failsafe_monitor_enable, oc.clock_switch_permit, oc.clkout_active,
           oc.current_oscillator_select, oc.use_external, oc.external_clock_mode,
           oc.crystal_mode, oc.osc_enabled, 4'h0},
          {ow[13], ow[11], ca, ro, ro inside {3'h7, 3'h2, 3'h1}, ext >= 3'h5,
           ext <= 3'h2, ext >= 3'h5 || ext <= 3'h2, 4'h0});
      if (ro == 3'h0) chk(14'({oc.fast_osc_frequency_select, oc.clock_divider_select}),
          14'({config_word_pkg::FAST_FRQ_DEFAULT, config_word_pkg::DIV_ONE}));
      if (ro == 3'h6) chk(14'(oc.fast_osc_frequency_select),
          14'(config_word_pkg::FAST_FRQ_ALT));
      if (ext != 3'h5 && ext != 3'h4 && ext != 3'h3) chk(14'(oc.program_memory_power),
          14'((ext == 3'h7 || ext == 3'h2) ? config_word_pkg::PMEM_HIGH : (ext == 3'h0) ?
          config_word_pkg::PMEM_LOW : config_word_pkg::PMEM_MID));
      chk({sc.debugger_enable, sc.stack_fault_reset_enable, sc.pin_select_one_shot_lock,
           sc.zero_cross_active, sc.brownout_low_level, sc.ultra_low_power_brownout,
           sc.powerup_timer_enable, sc.master_clear_active, sc.low_voltage_prog_enable,
           sc.code_protect_active, 4'h0},
          {~sw[13], sw[12], sw[11], ~sw[10], sw[9], ~sw[5], ~sw[1], pb[1] | sw[0], pb[1],
           ~pb[0], 4'h0});
      chk(14'({oc.pll_factor, sc.brownout_active, sc.brownout_in_sleep}),
          14'({ro == 3'h2, ro == 3'h1, sw[7], sw[7] & sw[6]}));
      tg = 0;
      prev = clkout;
      repeat (8) begin
        @(posedge sys_clk_i);
        #1;
        tg += int'(clkout !== prev) + int'(!ca && clkout === 1'b1);
        prev = clkout;
      end
      chk(14'(tg), ca ? 14'h4 : 14'h0);
      reg_wr(4'h0, ~ow);
      reg_rd(4'h0, ow | config_word_pkg::OSC_UNIMPL_MASK);
      reg_rd(4'h1, sw | config_word_pkg::SUP_UNIMPL_MASK);
      reg_rd(4'(5 + i % 11), 14'h0);
      mode = sw[7:6];
      for (int s = 0; s < 4; s++) begin
        reg_wr(4'h4, 14'(s));
        sleep <= s[0];
        @(posedge sys_clk_i);
        #1;
        chk(14'({zcd, bor}), 14'({~sw[10] | s[0], mode == 2'h3 | mode == 2'h2 & !s[0] |
            mode == 2'h1 & s[1]}));
      end
      reg_wr(4'h3, 14'h3);
      pulse(4'h8);
      chk(14'(sreset), 14'(sw[12]));
      reg_rd(4'h3, 14'h1);
      pulse(4'h4);
      chk(14'(sreset), 14'(sw[12]));
      reg_rd(4'h3, 14'h3);
      reg_wr(4'h3, 14'h3);
      reg_rd(4'h3, 14'h0);
      pulse(4'h2);
      chk(14'(lock), 14'h1);
      pulse(4'h1);
      pulse(4'h2);
      pulse(4'h1);
      chk(14'(lock), 14'(sw[11]));
      $display("test %0d done", i);
    end
    repeat (3) @(posedge sys_clk_i);
    end_of_test();
  end
endmodule
`default_nettype wire
